//--- include/pcds_pkg.sv
// constants, register map and mode encodings of the loop counter set
package pcds_pkg;
   localparam int PCDS_NOUT = 7;
   localparam int PCDS_CW = 9;
   localparam int PCDS_HW = 8;
   // register byte offsets
   localparam logic [7:0] PCDS_CTRL_OFF = 8'h00;
   localparam logic [7:0] PCDS_PRE_OFF = 8'h04;
   localparam logic [7:0] PCDS_MUL_OFF = 8'h08;
   localparam logic [7:0] PCDS_STAT_OFF = 8'h0C;
   localparam logic [7:0] PCDS_POST_OFF = 8'h10;
   // field positions
   localparam int PCDS_CTRL_MODE_LSB = 0;
   localparam int PCDS_CTRL_SRST_BIT = 3;
   localparam int PCDS_POST_HI_LSB = 0;
   localparam int PCDS_POST_LO_LSB = 8;
   localparam int PCDS_POST_BYP_BIT = 16;
   localparam int PCDS_STAT_OUT_LSB = 0;
   localparam int PCDS_STAT_CASC_LSB = 7;
   localparam int PCDS_STAT_FBIN_BIT = 14;
   localparam int PCDS_STAT_FBDRV_BIT = 15;
   // reset values (counts stored as value minus one)
   localparam logic [8:0] PCDS_PRE_RST = 9'h000;
   localparam logic [8:0] PCDS_MUL_RST = 9'h000;
   localparam logic [7:0] PCDS_HI_RST = 8'h00;
   localparam logic [7:0] PCDS_LO_RST = 8'h00;
   localparam logic [31:0] PCDS_UNMAPPED_RD = 32'h0000_0000;
   typedef enum logic [2:0] {
      PCDS_MODE_NORMAL = 3'h0,
      PCDS_MODE_ZERO_DELAY = 3'h1,
      PCDS_MODE_EXT_FB = 3'h3,
      PCDS_MODE_SRC_SYNC = 3'h2,
      PCDS_MODE_LVDS_COMP = 3'h6,
      PCDS_MODE_NO_COMP = 3'h7
   } pcds_mode_t;
endpackage : pcds_pkg

//--- logic/pcds_top.sv
// counter set around the loop: pre-scale, feedback multiply and seven post-scale dividers
`timescale 1ns/1ps
`default_nettype none
module pcds_top
   import pcds_pkg::*;
#(
   parameter logic [PCDS_NOUT-1:0] CASCADE_MASK = 7'h00,
   parameter int CAPTURE_IDX = 0
) (
   // clock and reset (clk_i is the oscillator rate)
   input wire logic clk_i,
   input wire logic rst_i,
   // loop side
   input wire logic ref_clk_i,
   input wire logic loop_reset_i,
   input wire logic fb_in_i,
   output logic pre_tick_o,
   output logic feedback_drive_out_o,
   output logic [PCDS_NOUT-1:0] out_clk_o,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   // refused at elaboration, the routing below cannot serve these
   if (CAPTURE_IDX < 0 || CAPTURE_IDX >= PCDS_NOUT) begin : g_bad_capture
      $error("capture output index out of range");
   end
   if (CASCADE_MASK[0]) begin : g_bad_cascade
      $error("first divider has no upstream divider to cascade from");
   end

   function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   //////////////////////////////////////////////////////////////////////////
   // register file
   logic wb_ack_q;
   logic [31:0] wb_dat_q;
   pcds_mode_t mode_q;
   logic srst_q;
   logic [PCDS_CW-1:0] pre_q;
   logic [PCDS_CW-1:0] mul_q;
   logic [PCDS_HW-1:0] hi_q [PCDS_NOUT];
   logic [PCDS_HW-1:0] lo_q [PCDS_NOUT];
   logic [PCDS_NOUT-1:0] byp_q;
   logic [PCDS_NOUT-1:0] out_q;
   logic fb_drv_q;
   logic fb_in_q;
   logic wb_req;
   logic wb_wr;
   logic [31:0] post_word [PCDS_NOUT];
   logic [31:0] ctrl_word;
   logic [31:0] rd_word;
   logic [31:0] wr_word;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
   assign wb_wr = wb_req && wb_we_i;
   assign ctrl_word = {28'h000_0000, srst_q, mode_q};
   // unselected lanes keep the addressed register's current bits
   assign wr_word = lane_merge(rd_word, wb_dat_i, wb_sel_i);

   always_comb begin
      for (int k = 0; k < PCDS_NOUT; k++) begin
         post_word[k] = 32'h0000_0000;
         post_word[k][PCDS_POST_HI_LSB +: PCDS_HW] = hi_q[k];
         post_word[k][PCDS_POST_LO_LSB +: PCDS_HW] = lo_q[k];
         post_word[k][PCDS_POST_BYP_BIT] = byp_q[k];
      end
   end

   always_comb begin
      rd_word = PCDS_UNMAPPED_RD;
      case (wb_adr_i)
         PCDS_CTRL_OFF: rd_word = ctrl_word;
         PCDS_PRE_OFF: rd_word = {23'h00_0000, pre_q};
         PCDS_MUL_OFF: rd_word = {23'h00_0000, mul_q};
         PCDS_STAT_OFF: begin
            rd_word[PCDS_STAT_OUT_LSB +: PCDS_NOUT] = out_q;
            rd_word[PCDS_STAT_CASC_LSB +: PCDS_NOUT] = CASCADE_MASK;
            rd_word[PCDS_STAT_FBIN_BIT] = fb_in_q;
            rd_word[PCDS_STAT_FBDRV_BIT] = fb_drv_q;
         end
         default: begin
            for (int k = 0; k < PCDS_NOUT; k++) begin
               if (wb_adr_i == PCDS_POST_OFF + 8'(4 * k)) begin
                  rd_word = post_word[k];
               end
            end
         end
      endcase
   end

   // single-wait-state answer; unmapped reads give zero, writes vanish
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= 32'h0000_0000;
      end else begin
         wb_ack_q <= wb_req;
         wb_dat_q <= wb_req ? rd_word : wb_dat_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= PCDS_MODE_NORMAL;
         srst_q <= 1'b0;
         pre_q <= PCDS_PRE_RST;
         mul_q <= PCDS_MUL_RST;
      end else if (wb_wr) begin
         case (wb_adr_i)
            PCDS_CTRL_OFF: begin
               mode_q <= pcds_mode_t'(wr_word[PCDS_CTRL_MODE_LSB +: 3]);
               srst_q <= wr_word[PCDS_CTRL_SRST_BIT];
            end
            PCDS_PRE_OFF: pre_q <= wr_word[PCDS_CW-1:0];
            PCDS_MUL_OFF: mul_q <= wr_word[PCDS_CW-1:0];
            default: begin
            end
         endcase
      end
   end

   // counts are held as value minus one so 1..256 and 1..512 fit exactly
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < PCDS_NOUT; k++) begin
            hi_q[k] <= PCDS_HI_RST;
            lo_q[k] <= PCDS_LO_RST;
         end
         byp_q <= 7'h00;
      end else if (wb_wr) begin
         for (int k = 0; k < PCDS_NOUT; k++) begin
            if (wb_adr_i == PCDS_POST_OFF + 8'(4 * k)) begin
               hi_q[k] <= wr_word[PCDS_POST_HI_LSB +: PCDS_HW];
               lo_q[k] <= wr_word[PCDS_POST_LO_LSB +: PCDS_HW];
               byp_q[k] <= wr_word[PCDS_POST_BYP_BIT];
            end
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // pre-scale and feedback multiply dividers
   logic clr;
   logic ref_q;
   logic ref_rise;
   logic [PCDS_CW-1:0] pre_cnt_q;
   logic pre_tick_q;
   logic [PCDS_CW-1:0] mul_cnt_q;
   logic mul_lvl_q;

   assign clr = loop_reset_i || srst_q;
   assign ref_rise = ref_clk_i && !ref_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_q <= 1'b0;
         fb_in_q <= 1'b0;
      end else begin
         ref_q <= ref_clk_i;
         fb_in_q <= fb_in_i;
      end
   end

   // one pulse per pre-scale reference edges, no duty-cycle settings
   always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
         pre_cnt_q <= 9'h000;
         pre_tick_q <= 1'b0;
      end else if (ref_rise) begin
         pre_tick_q <= (pre_cnt_q >= pre_q);
         pre_cnt_q <= (pre_cnt_q >= pre_q) ? 9'h000 : pre_cnt_q + 9'h001;
      end else begin
         pre_tick_q <= 1'b0;
      end
   end

   // multiply divider on the oscillator; high while count below half and at the terminal count
   always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
         mul_cnt_q <= 9'h000;
         mul_lvl_q <= 1'b0;
      end else begin
         mul_cnt_q <= (mul_cnt_q >= mul_q) ? 9'h000 : mul_cnt_q + 9'h001;
         mul_lvl_q <= (mul_q == 9'h000) || (mul_cnt_q >= mul_q) || (mul_cnt_q < (mul_q >> 1));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clr) begin
         fb_drv_q <= 1'b0;
      end else begin
         fb_drv_q <= (mode_q == PCDS_MODE_EXT_FB) && mul_lvl_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // post-scale dividers
   logic [PCDS_NOUT-1:0] tick_in;
   logic [PCDS_NOUT-1:0] rise_q;
   logic [PCDS_NOUT-1:0] phase_q;
   logic [PCDS_HW-1:0] cnt_q [PCDS_NOUT];

   for (genvar k = 0; k < PCDS_NOUT; k++) begin : g_post
      // upstream index stays in range for the first divider
      localparam int PREV = (k > 0) ? k - 1 : 0;
      // cascade routing is a build constant so runtime writes cannot alter it
      if (k > 0 && CASCADE_MASK[k]) begin : g_casc
         assign tick_in[k] = rise_q[k-1];
      end else begin : g_osc
         assign tick_in[k] = 1'b1;
      end

      always_ff @(posedge clk_i) begin
         if (rst_i || clr) begin
            cnt_q[k] <= 8'h00;
            phase_q[k] <= 1'b0;
            rise_q[k] <= 1'b0;
         end else if (tick_in[k] && byp_q[k]) begin
            rise_q[k] <= 1'b1;
            phase_q[k] <= 1'b1;
            cnt_q[k] <= 8'h00;
         end else if (tick_in[k]) begin
            // compare with >= so a shrinking count never overshoots
            if (phase_q[k] ? (cnt_q[k] >= hi_q[k]) : (cnt_q[k] >= lo_q[k])) begin
               phase_q[k] <= !phase_q[k];
               rise_q[k] <= !phase_q[k];
               cnt_q[k] <= 8'h00;
            end else begin
               cnt_q[k] <= cnt_q[k] + 8'h01;
               rise_q[k] <= 1'b0;
            end
         end else begin
            rise_q[k] <= 1'b0;
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i || clr) begin
            out_q[k] <= 1'b0;
         end else if (byp_q[k] && !CASCADE_MASK[k]) begin
            out_q[k] <= 1'b1;
         end else if (byp_q[k]) begin
            out_q[k] <= out_q[PREV];
         end else begin
            out_q[k] <= phase_q[k] ^ (k == CAPTURE_IDX && mode_q == PCDS_MODE_LVDS_COMP);
         end
      end
   end

   assign pre_tick_o = pre_tick_q;
   assign feedback_drive_out_o = fb_drv_q;
   assign out_clk_o = out_q;
   assign wb_dat_o = wb_dat_q;
   assign wb_ack_o = wb_ack_q;

   //////////////////////////////////////////////////////////////////////////
   // assertions
   property p_ack_next;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_q) |=> wb_ack_q ##1 !wb_ack_q;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus answer not one cycle after request");

   property p_loop_clear;
      @(posedge clk_i) disable iff (rst_i)
      loop_reset_i |=> (out_q == 7'h00) && !fb_drv_q && !pre_tick_q;
   endproperty
   a_loop_clear: assert property (p_loop_clear) else $error("loop reset left outputs set");

   property p_fb_mode;
      @(posedge clk_i) disable iff (rst_i || clr)
      (mode_q != PCDS_MODE_EXT_FB) |=> !fb_drv_q;
   endproperty
   a_fb_mode: assert property (p_fb_mode) else $error("feedback pin driven outside external mode");

   property p_fb_follow;
      @(posedge clk_i) disable iff (rst_i || clr)
      (mode_q == PCDS_MODE_EXT_FB) ##1 (mode_q == PCDS_MODE_EXT_FB) |-> fb_drv_q == $past(mul_lvl_q);
   endproperty
   a_fb_follow: assert property (p_fb_follow) else $error("feedback pin not following multiply divider");

   property p_pre_tick;
      @(posedge clk_i) disable iff (rst_i || clr)
      pre_tick_q |-> $past(ref_rise) && ($past(pre_cnt_q) >= $past(pre_q)) && (pre_cnt_q == 9'h000);
   endproperty
   a_pre_tick: assert property (p_pre_tick) else $error("pre-scale pulse at wrong count");

   property p_hold_high;
      @(posedge clk_i) disable iff (rst_i || clr)
      (!CASCADE_MASK[1] && phase_q[1] && !byp_q[1] && cnt_q[1] < hi_q[1])
         |=> phase_q[1] && (cnt_q[1] == $past(cnt_q[1]) + 8'h01);
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("output left high phase early");

   property p_hold_low;
      @(posedge clk_i) disable iff (rst_i || clr)
      (!phase_q[1] && !byp_q[1] && cnt_q[1] < lo_q[1]) |=> !phase_q[1];
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("output left low phase early");

   property p_rise_edge;
      @(posedge clk_i) disable iff (rst_i || clr)
      (rise_q[1] && !byp_q[1]) |-> phase_q[1] && !$past(phase_q[1]);
   endproperty
   a_rise_edge: assert property (p_rise_edge) else $error("rise pulse without low to high turn");

   property p_capture_inv;
      @(posedge clk_i) disable iff (rst_i || clr)
      (mode_q == PCDS_MODE_LVDS_COMP && !byp_q[CAPTURE_IDX]) ##1 (mode_q == PCDS_MODE_LVDS_COMP)
         |-> out_q[CAPTURE_IDX] == !$past(phase_q[CAPTURE_IDX]);
   endproperty
   a_capture_inv: assert property (p_capture_inv) else $error("capture output not inverted");

   property p_bypass;
      @(posedge clk_i) disable iff (rst_i || clr)
      (!CASCADE_MASK[3] && byp_q[3] && $past(byp_q[3]) && !$past(clr)) |-> out_q[3] && rise_q[3];
   endproperty
   a_bypass: assert property (p_bypass) else $error("ratio one does not pass input through");
endmodule : pcds_top
`default_nettype wire

//--- tb/pcds_far_model.sv
// reference source and board feedback trace beside the counter set
`timescale 1ns/1ps
`default_nettype none
module pcds_far_model #(
   parameter int REF_HALF = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // loop side
   input wire logic fb_drive_i,
   output logic ref_clk_o,
   output logic fb_in_o
);
   int cnt_q;
   // reference runs free, one rise every 2*REF_HALF cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 0;
         ref_clk_o <= 1'b0;
      end else if (cnt_q == REF_HALF - 1) begin
         cnt_q <= 0;
         ref_clk_o <= ~ref_clk_o;
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
   // trace delay of one cycle closes the loop
   always_ff @(posedge clk_i) begin
      fb_in_o <= rst_i ? 1'b0 : fb_drive_i;
   end
endmodule : pcds_far_model
`default_nettype wire

//--- tb/pcds_top_tb.sv
// self-checking bench of the loop counter set
`timescale 1ns/1ps
`default_nettype none
module pcds_top_tb;
   import pcds_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic loop_reset_i = 1'b0;
   logic ref_clk, fb_in, pre_tick_o, feedback_drive_out_o, wb_ack_o;
   logic [6:0] out_clk_o;
   logic [31:0] wb_dat_o;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rd;
   logic [7:0] mon;
   int failures = 0;
   int checks = 0;
   int n;
   assign mon = {feedback_drive_out_o, out_clk_o};
   // divider 5 is fed by divider 4 in this image
   pcds_top #(.CASCADE_MASK(7'h20), .CAPTURE_IDX(0)) pcds_top_inst (.clk_i(clk_i), .rst_i(rst_i),
      .ref_clk_i(ref_clk), .loop_reset_i(loop_reset_i), .fb_in_i(fb_in), .pre_tick_o(pre_tick_o),
      .feedback_drive_out_o(feedback_drive_out_o), .out_clk_o(out_clk_o), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   pcds_far_model #(.REF_HALF(4)) pcds_far_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .fb_drive_i(feedback_drive_out_o), .ref_clk_o(ref_clk), .fb_in_o(fb_in));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      if (failures == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic give_up(input int g, input int lim);
      if (g >= lim) begin
         failures++;
         end_sim();
      end
   endtask : give_up
   // entered just after a rising edge; request held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int g;
      g = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         g++;
      end while (wb_ack_o !== 1'b1 && g < 50);
      give_up(g, 50);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   // length of the next full run of mon[k] at level lv
   task automatic run_len(input int k, input logic lv, output int len);
      int g;
      g = 0;
      while (mon[k] === lv && g < 3000) begin
         @(posedge clk_i);
         g++;
      end
      while (mon[k] !== lv && g < 3000) begin
         @(posedge clk_i);
         g++;
      end
      len = 0;
      while (mon[k] === lv && g < 3000) begin
         @(posedge clk_i);
         g++;
         len++;
      end
      give_up(g, 3000);
   endtask : run_len
   // first two gaps are skipped, they may straddle the write of the count
   task automatic tick_gap(output int len);
      int g;
      g = 0;
      len = 0;
      for (int i = 0; i < 3; i++) begin
         len = 0;
         do begin
            @(posedge clk_i);
            g++;
            len++;
         end while (pre_tick_o !== 1'b1 && g < 15000);
      end
      give_up(g, 15000);
   endtask : tick_gap
   ////////////////////////////////////////
   task automatic t_reset();
      bus(0, PCDS_CTRL_OFF, 0);
      check(rd, 0);
      bus(0, PCDS_PRE_OFF, 0);
      check(rd, 0);
      bus(0, PCDS_MUL_OFF, 0);
      check(rd, 0);
      sel <= 4'h1;
      bus(1, PCDS_PRE_OFF, 32'hFFFF_FF05);
      sel <= 4'hF;
      bus(0, PCDS_PRE_OFF, 0);
      check(rd, 32'h0000_0005);
      bus(1, 8'hFC, 32'hFFFF_FFFF);
      bus(0, 8'hFC, 0);
      check(rd, PCDS_UNMAPPED_RD);
   endtask : t_reset
   task automatic t_post();
      bus(1, PCDS_POST_OFF + 8'h04, 32'h0000_0201);
      run_len(1, 1'b1, n);
      check(n, 2);
      run_len(1, 1'b0, n);
      check(n, 3);
      bus(1, PCDS_POST_OFF + 8'h08, 32'h0000_FFFF);
      run_len(2, 1'b1, n);
      check(n, 256);
      run_len(2, 1'b0, n);
      check(n, 256);
   endtask : t_post
   task automatic t_bypass();
      bus(1, PCDS_POST_OFF + 8'h0C, 32'h0001_0000);
      repeat (8) begin
         @(posedge clk_i);
         check(mon[3], 1'b1);
      end
   endtask : t_bypass
   task automatic t_cascade();
      bus(0, PCDS_STAT_OFF, 0);
      check(rd[13:7], 7'h20);
      bus(1, PCDS_STAT_OFF, 32'hFFFF_FFFF);
      bus(0, PCDS_STAT_OFF, 0);
      check(rd[13:7], 7'h20);
      bus(1, PCDS_POST_OFF + 8'h10, 32'h0000_0101);
      run_len(5, 1'b1, n);
      check(n, 4);
      run_len(5, 1'b0, n);
      check(n, 4);
   endtask : t_cascade
   task automatic t_pre();
      int vals [3] = '{0, 3, 511};
      foreach (vals[i]) begin
         bus(1, PCDS_PRE_OFF, vals[i]);
         tick_gap(n);
         check(n, 8 * (vals[i] + 1));
      end
   endtask : t_pre
   task automatic t_fb();
      bus(1, PCDS_MUL_OFF, 32'h0000_0003);
      bus(1, PCDS_CTRL_OFF, PCDS_MODE_EXT_FB);
      run_len(7, 1'b1, n);
      check(n, 2);
      run_len(7, 1'b0, n);
      check(n, 2);
      bus(1, PCDS_CTRL_OFF, PCDS_MODE_NORMAL);
      repeat (8) begin
         @(posedge clk_i);
         check(mon[7], 1'b0);
      end
   endtask : t_fb
   task automatic t_lvds();
      bus(1, PCDS_CTRL_OFF, PCDS_MODE_LVDS_COMP);
      repeat (2) @(posedge clk_i);
      repeat (8) begin
         @(posedge clk_i);
         check(mon[0] ^ mon[6], 1'b1);
      end
      bus(1, PCDS_CTRL_OFF, PCDS_MODE_NORMAL);
   endtask : t_lvds
   task automatic t_lreset();
      loop_reset_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      check({pre_tick_o, mon}, 0);
      loop_reset_i <= 1'b0;
      bus(1, PCDS_CTRL_OFF, 32'h0000_0008);
      repeat (2) @(posedge clk_i);
      check({pre_tick_o, mon}, 0);
      bus(0, PCDS_STAT_OFF, 0);
      check(rd, 32'h0000_1000);
      bus(1, PCDS_CTRL_OFF, 0);
      run_len(1, 1'b1, n);
      check(n, 2);
   endtask : t_lreset
   ////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_post();
      t_bypass();
      t_cascade();
      t_pre();
      t_fb();
      t_lvds();
      t_lreset();
      end_sim();
   end
endmodule : pcds_top_tb
`default_nettype wire
